/* pkg/sdpi_pkg.sv */
// constants and types shared by the sdram command pin interface
package sdpi_pkg;
  localparam int DATA_W     = 32;
  localparam int LANES      = 4;
  localparam int LANE_W     = 8;
  localparam int ADDR_W     = 11;
  localparam int BANK_W     = 2;
  localparam int BANKS      = 4;
  localparam int COL_W      = 8;
  localparam int AP_BIT     = 10;
  localparam int MASK_LAT   = 2;
  localparam int BURST_W    = 9;
  localparam logic [BURST_W-1:0] BURST_LEN_DEF = 9'h004;
  // command code: {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LMR   = 4'h0;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_WR    = 4'h4;
  localparam logic [3:0] CMD_RD    = 4'h5;
  localparam logic [3:0] CMD_BST   = 4'h6;
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [ADDR_W-1:0] MODE_RST = 11'h000;
  localparam logic [COL_W-1:0]  COL_ONE  = 8'h01;
  localparam logic [BURST_W-1:0] CNT_ONE = 9'h001;
  typedef enum logic [2:0] {SDPI_RUN, SDPI_PD_PRE, SDPI_SELF_REF, SDPI_PD_ACT,
                            SDPI_SUSPEND} sdpi_cke_t;
  typedef enum logic [1:0] {SDPI_B_IDLE, SDPI_B_RD, SDPI_B_WR} sdpi_burst_t;
endpackage

/* verilog/sdpi_mask_pipe.sv */
// byte mask delay line for read output enables
`timescale 1ns/10ps
`default_nettype none
module sdpi_mask_pipe
  import sdpi_pkg::*;
#(
  parameter int DEPTH = MASK_LAT
)(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             adv,
  input  wire logic [LANES-1:0] mask_in,
  output logic      [LANES-1:0] mask_out
);
  if (DEPTH < 1) $error("depth must be at least one");
  logic [LANES-1:0] stage_reg [DEPTH];
  logic [LANES-1:0] stage_next [DEPTH];
  // shift only while the clock is active, so suspend freezes the path
  always_comb
  begin
    stage_next[0] = adv ? mask_in : stage_reg[0];
    for (int i = 1; i < DEPTH; i++)
      stage_next[i] = adv ? stage_reg[i-1] : stage_reg[i];
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        stage_reg[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
        stage_reg[i] <= stage_next[i];
    end
  end
  assign mask_out = stage_reg[DEPTH-1];
endmodule
`default_nettype wire

/* verilog/sdpi_core.sv */
// device side command, address, mask and data pin logic of a four bank sdram
//
// Contract
// - every input is sampled only on the rising clock edge
// - each active cycle advances the burst column and clocks output registers
// - clock gate high means active; low freezes internal state
// - gate low picks power-down, self refresh, active power-down or suspend by state
// - gate sampled synchronously except while in power-down or self refresh; here it is sampled on every edge in those modes too
// - input buffers are disabled during power-down and self refresh
// - command decoder acts only when chip select is registered low
// - deselect lets bursts finish; byte masks still act
// - command code is chip select plus three strobes on one edge
// - chip select is one bit of the command code
// - write mask bit high blocks that byte from the array
// - read mask bit high floats that output byte two cycles later
// - mask bit n governs data bits 8n to 8n+7
// - mask referred to as a whole means all four bits alike
// - bank select picks bank for active, read, write, precharge
// - active captures all eleven address bits as the row
// - read or write takes low eight bits as column, bit ten auto precharge
// - precharge with bit ten high closes all banks, else selected bank
// - load mode register captures address as the opcode
`timescale 1ns/10ps
`default_nettype none
module sdpi_core
  import sdpi_pkg::*;
#(
  parameter logic [BURST_W-1:0] BURST_LEN = BURST_LEN_DEF
)(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              clk_gate,
  input  wire logic              chip_sel_n,
  input  wire logic              row_strobe_n,
  input  wire logic              col_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic [LANES-1:0]  byte_mask_lanes,
  input  wire logic [BANK_W-1:0] bank_select,
  input  wire logic [ADDR_W-1:0] address_bus,
  input  wire logic [DATA_W-1:0] data_lines_in,
  input  wire logic [DATA_W-1:0] array_rdata,
  output logic      [DATA_W-1:0] data_lines_out,
  output logic      [DATA_W-1:0] data_lines_oe,
  output logic                   array_we,
  output logic      [LANES-1:0]  array_be,
  output logic      [BANK_W-1:0] array_bank,
  output logic      [ADDR_W-1:0] array_row,
  output logic      [COL_W-1:0]  array_col,
  output logic      [DATA_W-1:0] array_wdata,
  output logic      [BANKS-1:0]  bank_open,
  output logic      [ADDR_W-1:0] mode_opcode,
  output logic                   mode_load,
  output logic                   refresh_pulse,
  output logic                   input_buf_en,
  output logic                   power_down,
  output logic                   self_refresh,
  output logic                   suspended
);
  if (BURST_LEN < CNT_ONE) $error("burst length must be at least one");

  // ****************************************************************
  // command decode
  // ****************************************************************
  sdpi_cke_t mode_reg, mode_next;
  sdpi_burst_t burst_reg, burst_next;
  logic [BANKS-1:0] open_reg, open_next;
  logic [3:0] cmd;
  logic       run;
  logic       gated_in;
  // buffers off in the low power modes, so strobes read as deselect
  assign gated_in = input_buf_en;
  assign cmd = gated_in ? {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n}
                        : {1'b1, 3'h7};
  assign run = clk_gate && (mode_reg == SDPI_RUN || mode_reg == SDPI_SUSPEND);

  function automatic logic is_cmd(input logic [3:0] c, input logic [3:0] code);
    is_cmd = (c == code); // a high cs bit never matches a code
  endfunction

  // ****************************************************************
  // clock gate mode
  // ****************************************************************
  logic ibuf_reg, ibuf_next, pd_reg, pd_next, sref_reg, sref_next, susp_reg, susp_next;
  // low power exit watches the gate every edge, standing in for the async path
  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      SDPI_RUN:
      begin
        if (!clk_gate)
        begin
          if (burst_reg != SDPI_B_IDLE) mode_next = SDPI_SUSPEND;
          else if (open_reg != '0)      mode_next = SDPI_PD_ACT;
          else if (is_cmd(cmd, CMD_REF)) mode_next = SDPI_SELF_REF;
          else                          mode_next = SDPI_PD_PRE;
        end
      end
      SDPI_PD_PRE, SDPI_PD_ACT, SDPI_SELF_REF, SDPI_SUSPEND:
        if (clk_gate) mode_next = SDPI_RUN;
    endcase
    pd_next   = (mode_next == SDPI_PD_PRE || mode_next == SDPI_PD_ACT);
    sref_next = (mode_next == SDPI_SELF_REF);
    susp_next = (mode_next == SDPI_SUSPEND);
    ibuf_next = !(pd_next || sref_next);
  end

  // ****************************************************************
  // banks, burst and mode register
  // ****************************************************************
  logic [ADDR_W-1:0] row_reg [BANKS];
  logic [ADDR_W-1:0] row_next [BANKS];
  logic [BURST_W-1:0] cnt_reg, cnt_next;
  logic [COL_W-1:0] col_reg, col_next;
  logic [BANK_W-1:0] bank_reg, bank_next;
  logic ap_reg, ap_next;
  logic [ADDR_W-1:0] mode_op_reg, mode_op_next;
  logic ld_next, ref_next;
  logic [LANES-1:0] rmask;
  logic [ADDR_W-1:0] arow_reg, arow_next;

  always_comb
  begin
    open_next = open_reg;
    burst_next = burst_reg;
    cnt_next = cnt_reg;
    col_next = col_reg;
    bank_next = bank_reg;
    ap_next = ap_reg;
    mode_op_next = mode_op_reg;
    ld_next = 1'b0;
    ref_next = 1'b0;
    for (int b = 0; b < BANKS; b++)
      row_next[b] = row_reg[b];
    if (run)
    begin
      // burst advance first; a read, write or burst stop below overrides it
      if (burst_reg != SDPI_B_IDLE)
      begin
        col_next = col_reg + COL_ONE;
        cnt_next = cnt_reg - CNT_ONE;
        if (cnt_reg == CNT_ONE)
        begin
          burst_next = SDPI_B_IDLE;
          if (ap_reg) open_next[bank_reg] = 1'b0;
        end
      end
      if (is_cmd(cmd, CMD_ACT))
      begin
        open_next[bank_select] = 1'b1;
        row_next[bank_select] = address_bus;
      end
      else if (is_cmd(cmd, CMD_RD) || is_cmd(cmd, CMD_WR))
      begin
        burst_next = is_cmd(cmd, CMD_RD) ? SDPI_B_RD
                   : (BURST_LEN == CNT_ONE) ? SDPI_B_IDLE : SDPI_B_WR;
        bank_next = bank_select;
        col_next = address_bus[COL_W-1:0];
        ap_next = address_bus[AP_BIT];
        // the write command cycle is its first beat, so one fewer follows
        cnt_next = is_cmd(cmd, CMD_RD) ? BURST_LEN : BURST_LEN - CNT_ONE;
        if (is_cmd(cmd, CMD_WR) && BURST_LEN == CNT_ONE && address_bus[AP_BIT])
          open_next[bank_select] = 1'b0;
      end
      else if (is_cmd(cmd, CMD_PRE))
      begin
        if (address_bus[AP_BIT]) open_next = '0;
        else open_next[bank_select] = 1'b0;
      end
      else if (is_cmd(cmd, CMD_BST))
        burst_next = SDPI_B_IDLE;
      else if (is_cmd(cmd, CMD_LMR))
      begin
        mode_op_next = address_bus;
        ld_next = 1'b1;
      end
      else if (is_cmd(cmd, CMD_REF))
        ref_next = 1'b1;
    end
    arow_next = row_next[bank_next];
  end

  // ****************************************************************
  // array and pin outputs
  // ****************************************************************
  logic [DATA_W-1:0] dout_next, doe_next, wdata_next;
  logic we_next;
  logic [LANES-1:0] be_next;
  logic [DATA_W-1:0] wdata_reg, dout_reg, doe_reg;
  logic we_reg;
  logic [LANES-1:0] be_reg;
  logic rd_phase;
  assign rd_phase = (burst_reg == SDPI_B_RD);

  always_comb
  begin
    dout_next = dout_reg;
    doe_next = doe_reg;
    wdata_next = wdata_reg;
    we_next = 1'b0;
    be_next = '0;
    if (run) // output registers clock only while active
    begin
      dout_next = array_rdata;
      for (int l = 0; l < LANES; l++)
        doe_next[l*LANE_W +: LANE_W] = {LANE_W{rd_phase && !rmask[l]}};
      if (burst_reg == SDPI_B_WR || is_cmd(cmd, CMD_WR))
      begin
        we_next = 1'b1;
        be_next = ~byte_mask_lanes;
        wdata_next = data_lines_in;
      end
    end
    else if (burst_reg == SDPI_B_IDLE)
      doe_next = '0; // nothing left to return, so let go of the bus
  end

  sdpi_mask_pipe #(
    .DEPTH    (MASK_LAT)
  ) u_mask (
    .core_clk (core_clk),
    .rst      (rst),
    .adv      (run),
    .mask_in  (byte_mask_lanes),
    .mask_out (rmask)
  );

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_reg <= SDPI_RUN;
      burst_reg <= SDPI_B_IDLE;
      open_reg <= '0;
      cnt_reg <= '0;
      col_reg <= '0;
      bank_reg <= '0;
      ap_reg <= 1'b0;
      mode_op_reg <= MODE_RST;
      mode_load <= 1'b0;
      refresh_pulse <= 1'b0;
      dout_reg <= '0;
      doe_reg <= '0;
      wdata_reg <= '0;
      we_reg <= 1'b0;
      be_reg <= '0;
      ibuf_reg <= 1'b1;
      pd_reg <= 1'b0;
      sref_reg <= 1'b0;
      susp_reg <= 1'b0;
      arow_reg <= '0;
      for (int b = 0; b < BANKS; b++)
        row_reg[b] <= '0;
    end
    else
    begin
      mode_reg <= mode_next;
      burst_reg <= burst_next;
      open_reg <= open_next;
      cnt_reg <= cnt_next;
      col_reg <= col_next;
      bank_reg <= bank_next;
      ap_reg <= ap_next;
      mode_op_reg <= mode_op_next;
      mode_load <= ld_next;
      refresh_pulse <= ref_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      wdata_reg <= wdata_next;
      we_reg <= we_next;
      be_reg <= be_next;
      ibuf_reg <= ibuf_next;
      pd_reg <= pd_next;
      sref_reg <= sref_next;
      susp_reg <= susp_next;
      arow_reg <= arow_next;
      for (int b = 0; b < BANKS; b++)
        row_reg[b] <= row_next[b];
    end
  end

  // status straight from state flops
  assign data_lines_out = dout_reg;
  assign data_lines_oe  = doe_reg;
  assign array_we       = we_reg;
  assign array_be       = be_reg;
  assign array_wdata    = wdata_reg;
  assign array_bank     = bank_reg;
  assign array_row      = arow_reg;
  assign array_col      = col_reg;
  assign bank_open      = open_reg;
  assign mode_opcode    = mode_op_reg;
  assign input_buf_en   = ibuf_reg;
  assign power_down     = pd_reg;
  assign self_refresh   = sref_reg;
  assign suspended      = susp_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_desel_ignored: assert property (@(posedge core_clk) disable iff (rst)
    (chip_sel_n && run) |=> !mode_load && !refresh_pulse)
    else $error("command taken while deselected");
  a_act_opens: assert property (@(posedge core_clk) disable iff (rst)
    (run && is_cmd(cmd, CMD_ACT)) |=> bank_open[$past(bank_select)])
    else $error("active did not open bank");
  a_pre_all: assert property (@(posedge core_clk) disable iff (rst)
    (run && is_cmd(cmd, CMD_PRE) && address_bus[AP_BIT]) |=> bank_open == '0)
    else $error("precharge all left a bank open");
  a_lmr_code: assert property (@(posedge core_clk) disable iff (rst)
    (run && is_cmd(cmd, CMD_LMR)) |=> mode_opcode == $past(address_bus))
    else $error("mode opcode not captured");
  a_wr_mask: assert property (@(posedge core_clk) disable iff (rst)
    (run && is_cmd(cmd, CMD_WR)) |=> array_we && array_be == ~$past(byte_mask_lanes))
    else $error("write mask not applied");
  sequence s_rd_masked;
    run && rd_phase && byte_mask_lanes[1] ##1 run ##1 run;
  endsequence
  a_rd_float: assert property (@(posedge core_clk) disable iff (rst)
    s_rd_masked |=> data_lines_oe[2*LANE_W-1:LANE_W] == '0)
    else $error("masked read lane still driven");
  a_frozen: assert property (@(posedge core_clk) disable iff (rst)
    (!run && !clk_gate) |=> $stable(array_col) && $stable(bank_open))
    else $error("state moved while clock gated");
  a_buf_off: assert property (@(posedge core_clk) disable iff (rst)
    (power_down || self_refresh) |-> !input_buf_en && !data_lines_oe[0])
    else $error("buffers active in low power");
  a_col_adv: assert property (@(posedge core_clk) disable iff (rst)
    (run && rd_phase && cnt_reg != CNT_ONE && (cmd[3] || cmd == CMD_NOP))
      |=> array_col == $past(array_col) + COL_ONE)
    else $error("burst column did not advance");
endmodule
`default_nettype wire

/* sim/sdpi_ctrl_model.sv */
// memory controller model that drives the device pins and answers array reads
`timescale 1ns/10ps
`default_nettype none
module sdpi_ctrl_model
  import sdpi_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic [BANK_W-1:0] array_bank,
  input  wire logic [COL_W-1:0]  array_col,
  output logic                   clk_gate,
  output logic      [3:0]        cmd,
  output logic      [LANES-1:0]  byte_mask_lanes,
  output logic      [BANK_W-1:0] bank_select,
  output logic      [ADDR_W-1:0] address_bus,
  output logic      [DATA_W-1:0] data_lines_in,
  output logic      [DATA_W-1:0] array_rdata
);
  // array answer is a pattern of its own location, so a wrong column shows
  assign array_rdata = {22'h0, array_bank, array_col};

  // pins idle deselected; gate tied high unless a scenario gates it
  initial
  begin
    clk_gate = 1'b1;
    cmd = 4'hF;
    byte_mask_lanes = 4'h0;
    bank_select = 2'h0;
    address_bus = 11'h000;
    data_lines_in = 32'h00000000;
  end

  // one command for one cycle; bank and address lines scramble afterwards, never hold stale
  task automatic issue(input logic [3:0] c, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic g);
    @(negedge core_clk);
    cmd = c;
    bank_select = b;
    address_bus = a;
    clk_gate = g;
    data_lines_in = (c == CMD_WR) ? 32'hA5C3_0F69 : ~data_lines_in;
    @(negedge core_clk);
    cmd = 4'hF;
    bank_select = ~b;
    address_bus = ~a;
  endtask

  // all four mask bits are driven together on every change
  task automatic set_mask(input logic [LANES-1:0] m);
    @(negedge core_clk);
    byte_mask_lanes = m;
  endtask

  // precharge all, two refreshes, then the mode load
  task automatic init(input logic [ADDR_W-1:0] op);
    issue(CMD_PRE, 2'h0, 11'h400, 1'b1);
    issue(CMD_REF, 2'h0, 11'h000, 1'b1);
    issue(CMD_REF, 2'h0, 11'h000, 1'b1);
    issue(CMD_LMR, 2'h0, op, 1'b1);
  endtask
endmodule
`default_nettype wire

/* sim/sdram_command_pin_interface_tb.sv */
// self-checking testbench of the device pin interface
`timescale 1ns/10ps
`default_nettype none
module sdram_command_pin_interface_tb;
  import sdpi_pkg::*;
  logic              core_clk, rst, clk_gate, array_we, mode_load, refresh_pulse;
  logic              input_buf_en, power_down, self_refresh, suspended;
  logic [3:0]        cmd;
  logic [LANES-1:0]  byte_mask_lanes, array_be;
  logic [BANK_W-1:0] bank_select, array_bank;
  logic [ADDR_W-1:0] address_bus, array_row, mode_opcode;
  logic [COL_W-1:0]  array_col;
  logic [BANKS-1:0]  bank_open;
  logic [DATA_W-1:0] data_lines_in, array_rdata, data_lines_out, data_lines_oe;
  logic [DATA_W-1:0] array_wdata, oe_or;
  logic              oe_watch;
  int                failures, n_tests, we_cnt, n, ref_cnt, ld_cnt;

  sdpi_core #(.BURST_LEN(9'h004)) DUT (.core_clk, .rst, .clk_gate,
    .chip_sel_n(cmd[3]), .row_strobe_n(cmd[2]), .col_strobe_n(cmd[1]),
    .write_strobe_n(cmd[0]), .byte_mask_lanes, .bank_select, .address_bus,
    .data_lines_in, .array_rdata, .data_lines_out, .data_lines_oe, .array_we,
    .array_be, .array_bank, .array_row, .array_col, .array_wdata, .bank_open,
    .mode_opcode, .mode_load, .refresh_pulse, .input_buf_en, .power_down,
    .self_refresh, .suspended);

  sdpi_ctrl_model ctl (.core_clk, .array_bank, .array_col, .clk_gate, .cmd,
    .byte_mask_lanes, .bank_select, .address_bus, .data_lines_in, .array_rdata);

  // ****************************************
  // clock, watchdog, beat monitor
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial
  begin
    #200000;
    failures++;
    finish_test();
  end

  // beats and driven lanes are gathered on the sampling edge only
  always @(posedge core_clk)
  begin
    we_cnt <= we_cnt + int'(array_we === 1'b1);
    ref_cnt <= ref_cnt + int'(refresh_pulse === 1'b1);
    ld_cnt <= ld_cnt + int'(mode_load === 1'b1);
    oe_or <= oe_watch ? (oe_or | data_lines_oe) : '0;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic idle(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_init();
    chk("reset_buf_en", 32'h1, input_buf_en);
    chk("reset_open", 32'h0, bank_open);
    ctl.init(11'h232);
    idle(2);
    chk("mode_opcode", 32'h232, mode_opcode);
    chk("refresh_cnt", 32'h2, 32'(ref_cnt));
    chk("load_cnt", 32'h1, 32'(ld_cnt));
  endtask

  // write with two lanes masked; deselect follows at once during the burst
  task automatic t_write();
    int i;
    ctl.issue(CMD_ACT, 2'h2, 11'h5A3, 1'b1);
    idle(1);
    chk("open_b2", 32'h4, bank_open);
    ctl.set_mask(4'h5);
    n = we_cnt;
    ctl.issue(CMD_WR, 2'h2, 11'h0FC, 1'b1);
    i = 0;
    while (array_we !== 1'b1 && i < 8)
    begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk("we_wait", 32'h0, 32'(i == 8));
    chk("wr_data", 32'hA5C30F69, array_wdata);
    chk("wr_bank", 32'h2, array_bank);
    chk("wr_row", 32'h5A3, array_row);
    chk("wr_col", 32'hFC, array_col);
    chk("wr_be", 32'hA, array_be);
    idle(8);
    chk("wr_beats", 32'h4, 32'(we_cnt - n));
  endtask

  // read with auto precharge, lane one masked before and through the burst
  task automatic t_read();
    ctl.set_mask(4'h2);
    idle(3);
    oe_watch = 1'b1;
    ctl.issue(CMD_RD, 2'h2, 11'h410, 1'b1);
    idle(1);
    chk("rd_data0", 32'h210, data_lines_out);
    chk("rd_lane_oe", 32'hFFFF00FF, data_lines_oe);
    idle(1);
    chk("rd_data1", 32'h211, data_lines_out);
    idle(10);
    chk("rd_oe", 32'hFFFF00FF, oe_or);
    chk("rd_autopre", 32'h0, bank_open);
    oe_watch = 1'b0;
  endtask

  task automatic t_bank();
    ctl.issue({1'b1, CMD_ACT[2:0]}, 2'h1, 11'h011, 1'b1);
    idle(1);
    chk("desel_act", 32'h0, bank_open);
    ctl.issue(CMD_ACT, 2'h1, 11'h011, 1'b1);
    ctl.issue(CMD_ACT, 2'h3, 11'h7FF, 1'b1);
    idle(1);
    chk("open_b1_b3", 32'hA, bank_open);
    ctl.issue(CMD_PRE, 2'h1, 11'h3FF, 1'b1);
    idle(1);
    chk("pre_one", 32'h8, bank_open);
    ctl.issue(CMD_ACT, 2'h0, 11'h001, 1'b1);
    ctl.issue(CMD_PRE, 2'h0, 11'h400, 1'b1);
    idle(1);
    chk("pre_all", 32'h0, bank_open);
  endtask

  task automatic t_power();
    ctl.issue(4'hF, 2'h0, 11'h000, 1'b0);
    idle(3);
    chk("pd", 32'h1, power_down);
    chk("pd_buf", 32'h0, input_buf_en);
    ctl.issue(4'hF, 2'h0, 11'h000, 1'b1);
    idle(3);
    chk("pd_exit", 32'h0, power_down);
    chk("pd_exit_buf", 32'h1, input_buf_en);
    ctl.issue(CMD_REF, 2'h0, 11'h000, 1'b0);
    idle(3);
    chk("sref", 32'h1, self_refresh);
    chk("sref_buf", 32'h0, input_buf_en);
    ctl.issue(4'hF, 2'h0, 11'h000, 1'b1);
    idle(3);
    chk("sref_exit", 32'h0, self_refresh);
  endtask

  // gate dropped in mid burst freezes the beats until it rises again
  task automatic t_suspend();
    int s;
    ctl.issue(CMD_ACT, 2'h0, 11'h001, 1'b1);
    ctl.set_mask(4'h0);
    s = we_cnt;
    ctl.issue(CMD_WR, 2'h0, 11'h020, 1'b1);
    ctl.issue(4'hF, 2'h0, 11'h000, 1'b0);
    chk("susp", 32'h1, suspended);
    n = we_cnt;
    idle(4);
    chk("susp_frozen", 32'(n), 32'(we_cnt));
    ctl.issue(4'hF, 2'h0, 11'h000, 1'b1);
    idle(8);
    chk("susp_beats", 32'h4, 32'(we_cnt - s));
  endtask

  initial
  begin
    rst = 1'b1;
    failures = 0;
    n_tests = 0;
    oe_watch = 1'b0;
    idle(6);
    rst = 1'b0;
    t_init();
    t_write();
    t_read();
    t_bank();
    t_power();
    t_suspend();
    finish_test();
  end
endmodule
`default_nettype wire
